// >>> uart_line_format_control.sv
// UART channel with line format control, Avalon-MM register slave
// Notes on behaviour
// - Divisor access bit opens divisor latch
// - Divisor access bit clear after reset
// - Break bit holds transmit line low
// - Break bit clear after reset
// - Forced parity acts only with parity enabled
// - Forced parity bit clear after reset
// - Forced, type zero: parity is one
// - Forced, type one: parity is zero
// - Unforced parity: type zero odd, one even
// - Parity enable clear: no parity bit
// - Divisor access shows special registers instead
// - Enhanced registers only while value BFh
`default_nettype none
module uart_line_format_control (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic uart_rx,
   output logic uart_tx
);
   import uart_lfc_pkg::*;

   // Shared by both engines so a received frame is judged by the same rule it is sent with
   function automatic logic parity_bit(input logic [7:0] d, input logic [7:0] f);
      if (f[FPAR_POS]) begin
         return ~f[PTYPE_POS];
      end
      return f[PTYPE_POS] ? ^d : ~^d;
   endfunction : parity_bit

   logic [7:0] line_format_control;
   logic [15:0] divisor;
   logic [7:0] enhanced_feature_register;
   logic [7:0] resume_char_one;
   logic [7:0] pause_char_one;
   tx_state_type tx_state, next_tx_state;
   rx_state_type rx_state, next_rx_state;
   logic [15:0] tx_cnt, rx_cnt;
   logic [2:0] tx_idx, rx_idx;
   logic [7:0] tx_hold, tx_shift, rx_shift, rx_data;
   logic rx_ready, par_err, par_bad;
   logic rx_s1, rx_s2, rx_s3, rx_line;
   logic next_tx_bit;

   // Bus decode: one wait cycle, then the access completes
   wire take = (read | write) & waitrequest;
   wire wr_ok = write & ~waitrequest;
   wire rd_ok = read & ~waitrequest;
   wire divisor_access_bit = line_format_control[DAB_POS];
   wire break_force_bit = line_format_control[BRK_POS];
   wire parity_enable_bit = line_format_control[PEN_POS];
   wire enh_open = (line_format_control == ENH_KEY);
   wire wr_lfc = wr_ok & (address == OFF_LFC);
   wire wr_data = wr_ok & (address == OFF_DATA);
   wire wr_aux = wr_ok & (address == OFF_AUX);
   wire wr_efr = wr_ok & (address == OFF_EFR) & enh_open;
   wire wr_resume = wr_ok & (address == OFF_RESUME) & enh_open;
   wire wr_pause = wr_ok & (address == OFF_PAUSE) & enh_open;
   wire wr_div_lo = wr_data & divisor_access_bit;
   wire wr_div_hi = wr_aux & divisor_access_bit;
   // A character offered while busy is dropped; software polls the busy flag
   wire tx_go = wr_data & ~divisor_access_bit & (tx_state == TX_IDLE);
   wire rx_take = rd_ok & (address == OFF_DATA) & ~divisor_access_bit;
   wire [7:0] status = {5'h00, tx_state != TX_IDLE, par_err, rx_ready};
   wire [7:0] rd_data_win = divisor_access_bit ? divisor[7:0] : rx_data;
   wire [7:0] rd_aux_win = divisor_access_bit ? divisor[15:8] : status;
   wire [7:0] rd_mux =
      (address == OFF_LFC) ? line_format_control :
      (address == OFF_DATA) ? rd_data_win :
      (address == OFF_AUX) ? rd_aux_win :
      (address == OFF_EFR && enh_open) ? enhanced_feature_register :
      (address == OFF_RESUME && enh_open) ? resume_char_one :
      (address == OFF_PAUSE && enh_open) ? pause_char_one : 8'h00;
   // A zero divisor would stall both engines, so it counts as one
   wire [15:0] bit_len = (divisor == 16'h0000) ? 16'h0001 : divisor;
   wire [15:0] half_len = (bit_len[15:1] == 15'h0000) ? 16'h0001 : {1'b0, bit_len[15:1]};
   wire tx_tick = (tx_cnt == 16'h0001);
   wire rx_tick = (rx_cnt == 16'h0001);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
      end else begin
         waitrequest <= ~take;
         if (take & read) begin
            readdata <= {24'h00_0000, rd_mux};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         line_format_control <= LFC_RESET;
         divisor <= DIV_RESET;
         enhanced_feature_register <= CHAR_RESET;
         resume_char_one <= CHAR_RESET;
         pause_char_one <= CHAR_RESET;
      end else begin
         if (wr_lfc) line_format_control <= writedata[7:0];
         if (wr_div_lo) divisor[7:0] <= writedata[7:0];
         if (wr_div_hi) divisor[15:8] <= writedata[7:0];
         if (wr_efr) enhanced_feature_register <= writedata[7:0];
         if (wr_resume) resume_char_one <= writedata[7:0];
         if (wr_pause) pause_char_one <= writedata[7:0];
      end
   end

   // Transmit framing
   always_comb begin
      next_tx_state = tx_state;
      next_tx_bit = 1'b1;
      case (tx_state)
         TX_IDLE: begin
            if (tx_go) next_tx_state = TX_START;
         end
         TX_START: begin
            next_tx_bit = 1'b0;
            if (tx_tick) next_tx_state = TX_DATA;
         end
         TX_DATA: begin
            next_tx_bit = tx_shift[0];
            if (tx_tick && tx_idx == LAST_BIT) begin
               next_tx_state = parity_enable_bit ? TX_PAR : TX_STOP;
            end
         end
         TX_PAR: begin
            next_tx_bit = parity_bit(tx_hold, line_format_control);
            if (tx_tick) next_tx_state = TX_STOP;
         end
         TX_STOP: begin
            if (tx_tick) next_tx_state = TX_IDLE;
         end
         default: next_tx_state = TX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tx_state <= TX_IDLE;
         tx_cnt <= 16'h0001;
         tx_idx <= 3'h0;
         tx_hold <= CHAR_RESET;
         tx_shift <= CHAR_RESET;
         uart_tx <= 1'b1;
      end else begin
         tx_state <= next_tx_state;
         // Break overrides whatever the framer is sending
         uart_tx <= break_force_bit ? 1'b0 : next_tx_bit;
         if (tx_state == TX_IDLE || tx_tick) begin
            tx_cnt <= bit_len;
         end else begin
            tx_cnt <= tx_cnt - 16'h0001;
         end
         if (tx_go) begin
            tx_hold <= writedata[7:0];
            tx_shift <= writedata[7:0];
            tx_idx <= 3'h0;
         end else if (tx_state == TX_DATA && tx_tick) begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_idx <= tx_idx + 3'h1;
         end
      end
   end

   // Receive: three stage sync, a level is accepted once stages two and three agree
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_s3 <= 1'b1;
         rx_line <= 1'b1;
      end else begin
         rx_s1 <= uart_rx;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3) rx_line <= rx_s3;
      end
   end

   always_comb begin
      next_rx_state = rx_state;
      case (rx_state)
         RX_IDLE: begin
            if (!rx_line) next_rx_state = RX_START;
         end
         RX_START: begin
            if (rx_tick) next_rx_state = rx_line ? RX_IDLE : RX_DATA;
         end
         RX_DATA: begin
            if (rx_tick && rx_idx == LAST_BIT) begin
               next_rx_state = parity_enable_bit ? RX_PAR : RX_STOP;
            end
         end
         RX_PAR: begin
            if (rx_tick) next_rx_state = RX_STOP;
         end
         RX_STOP: begin
            if (rx_tick) next_rx_state = RX_IDLE;
         end
         default: next_rx_state = RX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rx_state <= RX_IDLE;
         rx_cnt <= 16'h0001;
         rx_idx <= 3'h0;
         rx_shift <= CHAR_RESET;
         rx_data <= CHAR_RESET;
         par_bad <= 1'b0;
         rx_ready <= 1'b0;
         par_err <= 1'b0;
      end else begin
         rx_state <= next_rx_state;
         // Start bit is sampled mid-bit, later bits a full period apart
         if (rx_state == RX_IDLE) begin
            rx_cnt <= half_len;
         end else if (rx_tick) begin
            rx_cnt <= bit_len;
         end else begin
            rx_cnt <= rx_cnt - 16'h0001;
         end
         if (rx_state == RX_START) begin
            rx_idx <= 3'h0;
            par_bad <= 1'b0;
         end else if (rx_state == RX_DATA && rx_tick) begin
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_idx <= rx_idx + 3'h1;
         end
         if (rx_state == RX_PAR && rx_tick) begin
            par_bad <= (rx_line != parity_bit(rx_shift, line_format_control));
         end
         // A frame landing on the clearing read still raises its flags
         if (rx_state == RX_STOP && rx_tick) begin
            rx_data <= rx_shift;
            rx_ready <= 1'b1;
            par_err <= par_bad | (par_err & ~rx_take);
         end else if (rx_take) begin
            rx_ready <= 1'b0;
            par_err <= 1'b0;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_lfc_read_taken;
      take && read && address == OFF_LFC;
   endsequence
   sequence s_div_write_done;
      wr_div_lo;
   endsequence

   a_reset_clears_lfc: assert property ($fell(sys_rst) |-> line_format_control == 8'h00)
      else $error("line format control not clear after reset");
   a_break_holds_low: assert property (break_force_bit [*2] |-> !uart_tx)
      else $error("transmit line not low during break");
   a_idle_line_high: assert property (
      (!break_force_bit && tx_state == TX_IDLE) [*2] |-> uart_tx)
      else $error("idle line low without break");
   // A frame already running may move on; only a fresh start would be a leak
   a_divisor_access: assert property (s_div_write_done |=>
      divisor[7:0] == $past(writedata[7:0]) &&
      ($past(tx_state) != TX_IDLE || tx_state == TX_IDLE))
      else $error("divisor write not taken or leaked to transmitter");
   a_forced_one: assert property (
      tx_state == TX_PAR && line_format_control[6:3] == 4'b0101 |=> uart_tx)
      else $error("forced parity not one");
   a_forced_zero: assert property (
      tx_state == TX_PAR && line_format_control[6:3] == 4'b0111 |=> !uart_tx)
      else $error("forced parity not zero");
   a_odd_even_parity: assert property (
      tx_state == TX_PAR && line_format_control[6:5] == 2'b00 && parity_enable_bit
      |=> uart_tx == ($past(line_format_control[PTYPE_POS]) ? ^tx_hold : ~^tx_hold))
      else $error("computed parity wrong");
   a_no_parity_slot: assert property (
      tx_state == TX_DATA && tx_tick && tx_idx == LAST_BIT && !parity_enable_bit
      |=> tx_state == TX_STOP)
      else $error("parity slot sent while disabled");
   a_enhanced_gated: assert property (
      wr_ok && address == OFF_EFR && !enh_open |=> $stable(enhanced_feature_register))
      else $error("enhanced register written while closed");
   a_closed_reads_zero: assert property (
      take && read && address == OFF_EFR && !enh_open |=> readdata == 32'h0000_0000)
      else $error("enhanced register visible while closed");
   a_lfc_readback: assert property (s_lfc_read_taken |=>
      readdata == {24'h00_0000, line_format_control} && !waitrequest)
      else $error("line format control read back wrong");
   a_special_window: assert property (
      take && read && address == OFF_AUX && divisor_access_bit |=> readdata[7:0] == divisor[15:8])
      else $error("special register not shown");
endmodule : uart_line_format_control
`default_nettype wire

// >>> uart_lfc_pkg.sv
// Constants and types for the line format control block
`default_nettype none
package uart_lfc_pkg;
   localparam logic [4:0] OFF_LFC = 5'h00;
   localparam logic [4:0] OFF_DATA = 5'h04;
   localparam logic [4:0] OFF_AUX = 5'h08;
   localparam logic [4:0] OFF_EFR = 5'h0C;
   localparam logic [4:0] OFF_RESUME = 5'h10;
   localparam logic [4:0] OFF_PAUSE = 5'h14;
   localparam int DAB_POS = 7;
   localparam int BRK_POS = 6;
   localparam int FPAR_POS = 5;
   localparam int PTYPE_POS = 4;
   localparam int PEN_POS = 3;
   localparam int ST_RX_READY = 0;
   localparam int ST_PAR_ERR = 1;
   localparam int ST_TX_BUSY = 2;
   localparam logic [7:0] LFC_RESET = 8'h00;
   localparam logic [7:0] ENH_KEY = 8'hBF;
   localparam logic [15:0] DIV_RESET = 16'h0010;
   localparam logic [7:0] CHAR_RESET = 8'h00;
   localparam logic [2:0] LAST_BIT = 3'h7;
   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001,
      TX_START = 5'b00010,
      TX_DATA = 5'b00100,
      TX_PAR = 5'b01000,
      TX_STOP = 5'b10000
   } tx_state_type;
   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001,
      RX_START = 5'b00010,
      RX_DATA = 5'b00100,
      RX_PAR = 5'b01000,
      RX_STOP = 5'b10000
   } rx_state_type;
endpackage : uart_lfc_pkg
`default_nettype wire

// >>> uart_lfc_term.sv
// Remote serial terminal model on the far end of the UART line
`default_nettype none
module uart_lfc_term (
   input wire logic clk_sys,
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial line_out = 1'b1;
   // One frame, LSB first; no parity slot while pe is low
   task automatic send(input logic [7:0] d, input logic pe, input logic pb, input int bt);
      logic [9:0] f;
      f = {pb, d, 1'b0};
      for (int i = 0; i < (pe ? 10 : 9); i++) begin
         line_out <= f[i];
         repeat (bt) @(posedge clk_sys);
      end
      line_out <= 1'b1;
      repeat (bt) @(posedge clk_sys);
   endtask : send
   // Samples mid-bit; a one-cycle skew of the start bit stays inside the margin
   task automatic recv(input logic pe, input int bt, output logic [7:0] d,
                       output logic pb, output logic sb, output logic ok);
      ok = 1'b0;
      for (int k = 0; k < 400 && !ok; k++) begin
         @(posedge clk_sys);
         ok = (line_in === 1'b0);
      end
      repeat (bt / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         repeat (bt) @(posedge clk_sys);
         d[i] = line_in;
      end
      pb = 1'b1;
      if (pe) begin
         repeat (bt) @(posedge clk_sys);
         pb = line_in;
      end
      repeat (bt) @(posedge clk_sys);
      sb = line_in;
   endtask : recv
endmodule : uart_lfc_term
`default_nettype wire

// >>> uart_line_format_control_tb.sv
// Self-checking bench for the UART line format control block
`default_nettype none
module uart_line_format_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import uart_lfc_pkg::*;
   localparam logic [7:0] BT = 8'h06;
   localparam logic [7:0] CHR = 8'hA7;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, v;
   logic waitrequest, uart_rx, uart_tx, p, s, ok, pe, pb;
   logic [7:0] d, lfc;
   int n_errors = 0;
   int n_compared = 0;
   logic [7:0] modes [6] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h38, 8'h30};
   logic [4:0] enh [3] = '{OFF_EFR, OFF_RESUME, OFF_PAUSE};
   always #50 clk_sys = ~clk_sys;
   uart_line_format_control u_uart_line_format_control (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .uart_rx(uart_rx), .uart_tx(uart_tx));
   uart_lfc_term u_uart_lfc_term (.clk_sys(clk_sys), .line_in(uart_tx), .line_out(uart_rx));
   task automatic print_verdict();
      if (n_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   // Request held until waitrequest is sampled low; read data taken at that edge
   task automatic bus_cycle(input logic wr, input logic [4:0] a, input logic [7:0] dat,
                            output logic [31:0] q);
      int k;
      @(posedge clk_sys);
      address <= a;
      writedata <= {24'h0, dat};
      write <= wr;
      read <= !wr;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_sys);
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (k == 50) begin
         n_errors++;
         print_verdict();
      end
   endtask : bus_cycle
   // Polls status until a character is ready, then drains it
   task automatic rx_status(input logic [31:0] exp);
      for (int k = 0; k < 40; k++) begin
         bus_cycle(1'b0, OFF_AUX, 8'h00, v);
         if (v[ST_RX_READY] === 1'b1) break;
      end
      check(v, exp);
      bus_cycle(1'b0, OFF_DATA, 8'h00, v);
      check(v, {24'h0, CHR});
   endtask : rx_status
   initial begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      bus_cycle(1'b0, OFF_LFC, 8'h00, v);
      check(v, {24'h0, LFC_RESET});
      check(uart_tx, 1'b1);
      bus_cycle(1'b0, 5'h18, 8'h00, v);
      check(v, 32'h0);
      bus_cycle(1'b1, OFF_LFC, 8'h80, v);
      bus_cycle(1'b1, OFF_DATA, BT, v);
      bus_cycle(1'b1, OFF_AUX, 8'h01, v);
      bus_cycle(1'b0, OFF_AUX, 8'h00, v);
      check(v, 32'h01);
      bus_cycle(1'b1, OFF_AUX, 8'h00, v);
      bus_cycle(1'b0, OFF_DATA, 8'h00, v);
      check(v, {24'h0, BT});
      bus_cycle(1'b0, OFF_LFC, 8'h00, v);
      check(v, 32'h80);
      bus_cycle(1'b1, OFF_LFC, 8'h00, v);
      bus_cycle(1'b0, OFF_DATA, 8'h00, v);
      check(v, 32'h0);
      bus_cycle(1'b1, OFF_LFC, 8'h47, v);
      bus_cycle(1'b0, OFF_LFC, 8'h00, v);
      check(v, 32'h47);
      for (int k = 0; k < 30; k++) begin
         @(posedge clk_sys);
         check(uart_tx, 1'b0);
      end
      bus_cycle(1'b1, OFF_LFC, 8'h00, v);
      repeat (2) @(posedge clk_sys);
      check(uart_tx, 1'b1);
      bus_cycle(1'b1, OFF_EFR, 8'h55, v);
      bus_cycle(1'b0, OFF_EFR, 8'h00, v);
      check(v, 32'h0);
      bus_cycle(1'b1, OFF_LFC, ENH_KEY, v);
      for (int i = 0; i < 3; i++) begin
         bus_cycle(1'b1, enh[i], 8'h51 + 8'(i), v);
         bus_cycle(1'b0, enh[i], 8'h00, v);
         check(v, 32'h51 + i);
      end
      bus_cycle(1'b1, OFF_LFC, 8'hBE, v);
      bus_cycle(1'b0, OFF_EFR, 8'h00, v);
      check(v, 32'h0);
      for (int m = 0; m < 6; m++) begin
         lfc = modes[m];
         pe = lfc[PEN_POS];
         pb = lfc[FPAR_POS] ? ~lfc[PTYPE_POS] : (^CHR ^ ~lfc[PTYPE_POS]);
         bus_cycle(1'b1, OFF_LFC, lfc, v);
         bus_cycle(1'b1, OFF_DATA, CHR, v);
         u_uart_lfc_term.recv(pe, BT, d, p, s, ok);
         check({ok, s, d}, {2'b11, CHR});
         check(p, pe ? pb : 1'b1);
         u_uart_lfc_term.send(CHR, pe, pb, BT);
         rx_status(32'h1);
         if (lfc[FPAR_POS] && pe) begin
            u_uart_lfc_term.send(CHR, 1'b1, ~pb, BT);
            rx_status(32'h3);
         end
      end
      print_verdict();
   end
endmodule : uart_line_format_control_tb
`default_nettype wire
